// File: core/irq_ctrl.sv
// Interrupt controller with time base, hardware stack and bus registers
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// - Source events set their request flags regardless of their own enable, except the pin; group flags need a member enable.
// - A source is taken only while its own enable is high.
// - Nothing is taken while the global enable is zero.
// - Taking pushes the next-instruction address, then loads the vector.
// - Return from interrupt pops the saved address back into the PC.
// - Return from interrupt sets the global enable; plain return leaves it.
// - Servicing an interrupt clears the global enable.
// - Requests during service still latch and stay pending.
// - No request is taken while the stack is full.
// - Simultaneous enabled requests are served by fixed priority.
// - Any flag being set wakes the device from sleep or idle.
// - Wake-up comes from a flag rising, independent of enables.
// - Edge select: 00 off, 01 rise, 10 fall, 11 both; resets 11.
// - The pin flag sets on the selected edge; off stops it.
// - The pin acts as interrupt input only while its enable is set.
// - Servicing the pin interrupt clears the pin flag.
// - Comparator flag sets on output change, clears on service.
// - A group flag sets when any member whose enable is set sets its flag.
// - Service clears only the group flag, never member flags.
// - Converter flag sets on conversion end, clears on service.
// - Time base flags set on divider overflow, clear on service.
// - A programmable divider sets each time base period.
// - Time base A 256..32768, B 4096..32768 clocks, powers of two.
// - Third-timer group: flags bits 6..4, enables bits 2..0, reset zero.
// - EEPROM/low-voltage group: flags bits 5,4, enables 1,0, reset zero.
// - Unimplemented group bits read zero and ignore writes.
module irq_ctrl (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [5:0] address, // Byte address
	input wire logic read, // Read request
	input wire logic write, // Write request
	input wire logic [31:0] writedata, // Write data
	output logic [31:0] readdata, // Read data
	output logic waitrequest, // Slave stall
	input wire logic ext_pin, // External interrupt pin
	input wire logic comparator_out, // Comparator output level
	input wire logic adc_done, // Conversion finished pulse
	input wire logic [3:0] tmr01_match, // Timer 0/1 matches, flag order
	input wire logic [2:0] tmr3_match, // Third timer B, A, P matches
	input wire logic eeprom_done, // EEPROM cycle end pulse
	input wire logic low_supply, // Low voltage detect pulse
	input wire logic timebase_source_clock, // Time base source
	input wire logic [11:0] next_pc, // Address of next instruction
	input wire logic call_req, // Core subroutine call
	input wire logic ret_req, // Plain return
	input wire logic return_from_interrupt, // Interrupt return
	output logic pc_load, // Load PC pulse
	output logic [11:0] pc_addr, // Address to load
	output logic stack_full, // Stack full
	output logic wake, // Wake-up pulse
	output logic pin_irq_mode // Pin used as interrupt input
);

	// ==========================================
	// State
	logic [2:0] pin_s_reg, pin_s_next, tbs_s_reg, tbs_s_next;
	logic pin_lvl_reg, pin_lvl_next, tbs_lvl_reg, tbs_lvl_next;
	logic cmp_prev_reg, cmp_prev_next;
	logic [1:0] div_reg, div_next;
	logic [14:0] tb_cnt_reg, tb_cnt_next;
	logic global_irq_enable_reg, global_irq_enable_next;
	logic [7:0] en_reg, en_next, fl_reg, fl_next;
	logic [1:0] edge_select_reg, edge_select_next;
	logic [7:0] timebase_control_reg, timebase_control_next;
	logic [7:0] grp0_reg, grp0_next;
	logic [7:0] timer2_irq_flags_enables_reg, timer2_irq_flags_enables_next;
	logic [7:0] eeprom_lowvolt_irq_flags_enables_reg;
	logic [7:0] eeprom_lowvolt_irq_flags_enables_next;
	logic wait_reg, wait_next, wake_reg, wake_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [2:0] sp_reg, sp_next;
	logic [11:0] pca_reg, pca_next, stk_reg [4], stk_next [4];
	logic pcl_reg, pcl_next, full_reg, full_next;

	// ==========================================
	// Event detection and time base
	logic pin_stable, pin_rise, pin_fall, pin_evt;
	logic tbs_stable, tbs_rise, tb_tick, ovf_a, ovf_b, cmp_evt;
	logic [14:0] mask_a, mask_b;

	always_comb begin
		pin_s_next = {pin_s_reg[1:0], ext_pin};
		tbs_s_next = {tbs_s_reg[1:0], timebase_source_clock};
		pin_stable = pin_s_reg[1] == pin_s_reg[2];
		tbs_stable = tbs_s_reg[1] == tbs_s_reg[2];
		pin_lvl_next = pin_stable ? pin_s_reg[2] : pin_lvl_reg;
		tbs_lvl_next = tbs_stable ? tbs_s_reg[2] : tbs_lvl_reg;
		pin_rise = pin_stable & pin_s_reg[2] & ~pin_lvl_reg;
		pin_fall = pin_stable & ~pin_s_reg[2] & pin_lvl_reg;
		tbs_rise = tbs_stable & tbs_s_reg[2] & ~tbs_lvl_reg;
		// Bit 0 of the select enables rising, bit 1 falling
		pin_evt = en_reg[irq_pkg::SRC_PIN] &
			((edge_select_reg[0] & pin_rise) |
			(edge_select_reg[1] & pin_fall));
		cmp_prev_next = comparator_out;
		cmp_evt = comparator_out ^ cmp_prev_reg;
		div_next = div_reg + 2'h1;
		tb_tick = timebase_control_reg[irq_pkg::TBC_ON_BIT] &
			(timebase_control_reg[irq_pkg::TBC_CK_BIT] ?
			(div_reg == irq_pkg::DIV4_LAST) : tbs_rise);
		tb_cnt_next = tb_cnt_reg + 15'(tb_tick);
		if (!timebase_control_reg[irq_pkg::TBC_ON_BIT]) begin
			tb_cnt_next = '0;
		end
		// Both time bases tap one shared counter
		mask_a = irq_pkg::TB_CNT_MAX >>
			(irq_pkg::TB_A_SEL_MAX - timebase_control_reg[2:0]);
		mask_b = irq_pkg::TB_CNT_MAX >>
			(irq_pkg::TB_B_SEL_MAX - timebase_control_reg[5:4]);
		ovf_a = tb_tick & ((tb_cnt_reg & mask_a) == mask_a);
		ovf_b = tb_tick & ((tb_cnt_reg & mask_b) == mask_b);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pin_s_reg <= '0;
			tbs_s_reg <= '0;
			pin_lvl_reg <= 1'b0;
			tbs_lvl_reg <= 1'b0;
			cmp_prev_reg <= 1'b0;
			div_reg <= '0;
			tb_cnt_reg <= '0;
		end else begin
			pin_s_reg <= pin_s_next;
			tbs_s_reg <= tbs_s_next;
			pin_lvl_reg <= pin_lvl_next;
			tbs_lvl_reg <= tbs_lvl_next;
			cmp_prev_reg <= cmp_prev_next;
			div_reg <= div_next;
			tb_cnt_reg <= tb_cnt_next;
		end
	end

	// ==========================================
	// Arbitration
	logic [7:0] act;
	logic [2:0] sel;
	logic take, core_busy;

	always_comb begin
		act = fl_reg & en_reg;
		core_busy = call_req | ret_req | return_from_interrupt;
		sel = '0;
		for (int i = irq_pkg::NSRC - 1; i >= 0; i--) begin
			sel = act[i] ? 3'(i) : sel;
		end
		// Full stack holds requests pending; core ops go first
		take = global_irq_enable_reg & (|act) & ~full_reg &
			~core_busy;
	end

	// ==========================================
	// Registers and bus slave
	logic wr_fire;
	logic [7:0] wd, hw_set, svc_clr, g2_set;
	logic g0_evt, g1_evt, g2_evt;

	always_comb begin
		wd = writedata[7:0];
		wr_fire = write & ~wait_reg;
		g0_evt = |(tmr01_match & grp0_reg[3:0]);
		g1_evt = |(tmr3_match & timer2_irq_flags_enables_reg[2:0]);
		g2_evt = |({eeprom_done, low_supply} &
			eeprom_lowvolt_irq_flags_enables_reg[1:0]);
		hw_set = {ovf_b, ovf_a, adc_done, g2_evt, g1_evt, g0_evt,
			cmp_evt, pin_evt};
		svc_clr = take ? (8'h01 << sel) : 8'h00;
		global_irq_enable_next = global_irq_enable_reg;
		en_next = en_reg;
		fl_next = fl_reg;
		edge_select_next = edge_select_reg;
		timebase_control_next = timebase_control_reg;
		grp0_next = grp0_reg;
		timer2_irq_flags_enables_next = timer2_irq_flags_enables_reg;
		eeprom_lowvolt_irq_flags_enables_next =
			eeprom_lowvolt_irq_flags_enables_reg;
		if (wr_fire) begin
			case (address)
				irq_pkg::OFS_CTRL0: begin
					global_irq_enable_next = wd[irq_pkg::GIE_BIT];
					en_next[2:0] = wd[3:1];
					fl_next[2:0] = wd[6:4];
				end
				irq_pkg::OFS_CTRL1: begin
					en_next[6:3] = wd[3:0];
					fl_next[6:3] = wd[7:4];
				end
				irq_pkg::OFS_CTRL2: begin
					en_next[irq_pkg::SRC_TBB] = wd[0];
					fl_next[irq_pkg::SRC_TBB] = wd[irq_pkg::FLAG_LSB];
				end
				irq_pkg::OFS_EDGE: edge_select_next = wd[1:0];
				irq_pkg::OFS_TBC: timebase_control_next = wd & irq_pkg::TBC_MASK;
				irq_pkg::OFS_GRP0: grp0_next = wd & irq_pkg::GRP0_MASK;
				irq_pkg::OFS_GRP1: timer2_irq_flags_enables_next =
					wd & irq_pkg::GRP1_MASK;
				irq_pkg::OFS_GRP2: eeprom_lowvolt_irq_flags_enables_next =
					wd & irq_pkg::GRP2_MASK;
				default: ;
			endcase
		end
		if (take) begin
			global_irq_enable_next = 1'b0;
		end else if (return_from_interrupt) begin
			global_irq_enable_next = 1'b1;
		end
		// Hardware set wins over any clear in the same cycle
		fl_next = (fl_next & ~svc_clr) | hw_set;
		grp0_next = grp0_next | {tmr01_match, 4'h0};
		timer2_irq_flags_enables_next = timer2_irq_flags_enables_next |
			{1'b0, tmr3_match, 4'h0};
		g2_set = {2'h0, eeprom_done, low_supply, 4'h0};
		eeprom_lowvolt_irq_flags_enables_next =
			eeprom_lowvolt_irq_flags_enables_next | g2_set;
		wake_next = (|(fl_next & ~fl_reg)) |
			(|(grp0_next & ~grp0_reg & irq_pkg::GRP_FLAGS)) |
			(|(timer2_irq_flags_enables_next &
			~timer2_irq_flags_enables_reg & irq_pkg::GRP_FLAGS)) |
			(|(eeprom_lowvolt_irq_flags_enables_next &
			~eeprom_lowvolt_irq_flags_enables_reg &
			irq_pkg::GRP_FLAGS));
		// One wait cycle per access; a stalled request is never taken twice
		wait_next = ~((read | write) & wait_reg);
		rdata_next = rdata_reg;
		if (read & wait_reg) begin
			case (address)
				irq_pkg::OFS_CTRL0: rdata_next = {25'h0, fl_reg[2:0],
					en_reg[2:0], global_irq_enable_reg};
				irq_pkg::OFS_CTRL1: rdata_next = {24'h0, fl_reg[6:3],
					en_reg[6:3]};
				irq_pkg::OFS_CTRL2: rdata_next = {27'h0, fl_reg[7], 3'h0,
					en_reg[7]};
				irq_pkg::OFS_EDGE: rdata_next = {30'h0, edge_select_reg};
				irq_pkg::OFS_TBC: rdata_next = {24'h0, timebase_control_reg};
				irq_pkg::OFS_GRP0: rdata_next = {24'h0, grp0_reg};
				irq_pkg::OFS_GRP1: rdata_next = {24'h0,
					timer2_irq_flags_enables_reg};
				irq_pkg::OFS_GRP2: rdata_next = {24'h0,
					eeprom_lowvolt_irq_flags_enables_reg};
				irq_pkg::OFS_STAT: rdata_next = {28'h0, full_reg, sp_reg};
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			global_irq_enable_reg <= 1'b0;
			en_reg <= '0;
			fl_reg <= '0;
			edge_select_reg <= irq_pkg::EDGE_RST;
			timebase_control_reg <= irq_pkg::TBC_RST;
			grp0_reg <= irq_pkg::GRP_RST;
			timer2_irq_flags_enables_reg <= irq_pkg::GRP_RST;
			eeprom_lowvolt_irq_flags_enables_reg <= irq_pkg::GRP_RST;
			wait_reg <= 1'b1;
			wake_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			global_irq_enable_reg <= global_irq_enable_next;
			en_reg <= en_next;
			fl_reg <= fl_next;
			edge_select_reg <= edge_select_next;
			timebase_control_reg <= timebase_control_next;
			grp0_reg <= grp0_next;
			timer2_irq_flags_enables_reg <= timer2_irq_flags_enables_next;
			eeprom_lowvolt_irq_flags_enables_reg <=
				eeprom_lowvolt_irq_flags_enables_next;
			wait_reg <= wait_next;
			wake_reg <= wake_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================
	// Hardware stack and program counter load
	always_comb begin
		sp_next = sp_reg;
		stk_next = stk_reg;
		pcl_next = 1'b0;
		pca_next = pca_reg;
		if (take) begin
			stk_next[sp_reg[1:0]] = next_pc;
			sp_next = sp_reg + 3'h1;
			pcl_next = 1'b1;
			pca_next = irq_pkg::VEC_BASE +
				(12'(sel) << irq_pkg::VEC_SHIFT);
		end else if (call_req && !full_reg) begin
			stk_next[sp_reg[1:0]] = next_pc;
			sp_next = sp_reg + 3'h1;
		end else if ((ret_req | return_from_interrupt) &&
			sp_reg != 3'h0) begin
			sp_next = sp_reg - 3'h1;
			pca_next = stk_reg[2'(sp_reg - 3'h1)];
			pcl_next = 1'b1;
		end
		full_next = sp_next == irq_pkg::STACK_DEPTH;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sp_reg <= '0;
			stk_reg <= '{default: 12'h000};
			pcl_reg <= 1'b0;
			pca_reg <= '0;
			full_reg <= 1'b0;
		end else begin
			sp_reg <= sp_next;
			stk_reg <= stk_next;
			pcl_reg <= pcl_next;
			pca_reg <= pca_next;
			full_reg <= full_next;
		end
	end

	assign readdata = rdata_reg;
	assign waitrequest = wait_reg;
	assign pc_load = pcl_reg;
	assign pc_addr = pca_reg;
	assign stack_full = full_reg;
	assign wake = wake_reg;
	assign pin_irq_mode = en_reg[irq_pkg::SRC_PIN];

	// ==========================================
	// Checks
	default clocking chk_cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_take_needs_enable: assert property (
		take |-> global_irq_enable_reg && act[sel])
		else $error("taken without global or own enable");
	chk_full_blocks_take: assert property (stack_full |-> !take)
		else $error("taken while stack full");
	chk_take_clears_gie: assert property (
		take |=> !global_irq_enable_reg && pc_load)
		else $error("service left global enable set");
	chk_vector_load: assert property (take |=> pc_addr ==
		irq_pkg::VEC_BASE + (12'($past(sel)) << irq_pkg::VEC_SHIFT))
		else $error("wrong vector loaded");
	chk_priority_order: assert property (
		take |-> (act & ((8'h01 << sel) - 8'h01)) == 8'h00)
		else $error("lower priority source won");
	chk_return_from_interrupt_sets_gie: assert property (
		return_from_interrupt && !take |=> global_irq_enable_reg)
		else $error("interrupt return left global enable low");
	chk_ret_keeps_gie: assert property (
		ret_req && !return_from_interrupt && !global_irq_enable_reg &&
		!wr_fire |=> !global_irq_enable_reg)
		else $error("plain return set global enable");
	chk_flag_rise_wakes: assert property (
		$rose(fl_reg[irq_pkg::SRC_ADC]) |-> wake)
		else $error("flag rise without wake");
	chk_adc_sets_flag: assert property (
		adc_done |=> fl_reg[irq_pkg::SRC_ADC])
		else $error("conversion end lost");
	chk_edge_off: assert property (
		edge_select_reg == 2'h0 |-> !pin_evt)
		else $error("pin event with edge select off");
	chk_member_kept: assert property (
		take && sel == 3'(irq_pkg::SRC_MF2) && !wr_fire |=>
		eeprom_lowvolt_irq_flags_enables_reg[5:4] ==
		$past(eeprom_lowvolt_irq_flags_enables_reg[5:4]))
		else $error("service cleared a member flag");

endmodule : irq_ctrl

// File: include/irq_pkg.sv
// Constants shared by the interrupt controller
package irq_pkg;

	// ==========================================
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL0 = 6'h00;
	localparam logic [5:0] OFS_CTRL1 = 6'h04;
	localparam logic [5:0] OFS_CTRL2 = 6'h08;
	localparam logic [5:0] OFS_EDGE = 6'h0C;
	localparam logic [5:0] OFS_TBC = 6'h10;
	localparam logic [5:0] OFS_GRP0 = 6'h14;
	localparam logic [5:0] OFS_GRP1 = 6'h18;
	localparam logic [5:0] OFS_GRP2 = 6'h1C;
	localparam logic [5:0] OFS_STAT = 6'h20;

	// ==========================================
	// Source index order, lowest index wins
	localparam int SRC_PIN = 0;
	localparam int SRC_CMP = 1;
	localparam int SRC_MF0 = 2;
	localparam int SRC_MF1 = 3;
	localparam int SRC_MF2 = 4;
	localparam int SRC_ADC = 5;
	localparam int SRC_TBA = 6;
	localparam int SRC_TBB = 7;
	localparam int NSRC = 8;

	// ==========================================
	// Field positions and reset values
	localparam int GIE_BIT = 0;
	localparam int FLAG_LSB = 4;
	localparam int TBC_ON_BIT = 7;
	localparam int TBC_CK_BIT = 6;
	localparam logic [1:0] EDGE_RST = 2'h3;
	localparam logic [7:0] TBC_RST = 8'h37;
	localparam logic [7:0] TBC_MASK = 8'hF7;
	localparam logic [7:0] GRP_RST = 8'h00;
	localparam logic [7:0] GRP0_MASK = 8'hFF;
	localparam logic [7:0] GRP1_MASK = 8'h77;
	localparam logic [7:0] GRP2_MASK = 8'h33;
	localparam logic [7:0] GRP_FLAGS = 8'hF0;

	// ==========================================
	// Time base dividers
	localparam logic [14:0] TB_CNT_MAX = 15'h7FFF;
	localparam logic [2:0] TB_A_SEL_MAX = 3'h7;
	localparam logic [1:0] TB_B_SEL_MAX = 2'h3;
	localparam logic [1:0] DIV4_LAST = 2'h3;

	// ==========================================
	// Program counter, stack and vectors
	localparam int PC_W = 12;
	localparam int SP_W = 3;
	localparam logic [2:0] STACK_DEPTH = 3'h4;
	localparam logic [11:0] VEC_BASE = 12'h004;
	localparam int VEC_SHIFT = 2;

endpackage : irq_pkg

// File: verification/core_model.sv
// Behavioural processor core: program counter and call/return pulses
`timescale 1ns/10ps
// ==========================================
// Core model
module core_model #(
	parameter logic [11:0] START_PC = 12'h100
) (
	input wire logic clk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic [2:0] op_cmd, // Bench order: return_from_interrupt, ret, call
	input wire logic pc_load, // Load PC pulse
	input wire logic [11:0] pc_addr, // Address to load
	output logic [11:0] next_pc, // Address of next instruction
	output logic call_req, // Subroutine call pulse
	output logic ret_req, // Plain return pulse
	output logic return_from_interrupt // Interrupt return pulse
);
	logic [11:0] pc_reg;
	logic [11:0] pc_next;
	logic [2:0] op_reg;
	logic [2:0] op_next;

	// Core stalls between loads, so a take right after a load must
	// save the freshly loaded address, not a stale one
	always_comb begin
		pc_next = pc_reg;
		if (pc_load)
			pc_next = pc_addr;
		op_next = op_cmd;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pc_reg <= START_PC;
			op_reg <= 3'h0;
		end else begin
			pc_reg <= pc_next;
			op_reg <= op_next;
		end
	end

	assign next_pc = pc_next;
	assign call_req = op_reg[0];
	assign ret_req = op_reg[1];
	assign return_from_interrupt = op_reg[2];
endmodule : core_model

// File: verification/irq_ctrl_tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
// ==========================================
// Bench
module irq_ctrl_tb_top;
	logic clk;
	logic rst;
	logic [5:0] address;
	logic read;
	logic write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic waitrequest;
	logic ext_pin;
	logic comparator_out;
	logic [9:0] src;
	logic tb_src_clk;
	logic [11:0] next_pc;
	logic call_req;
	logic ret_req;
	logic return_from_interrupt_req;
	logic [2:0] op_cmd;
	logic pc_load;
	logic [11:0] pc_addr;
	logic stack_full;
	logic wake;
	logic pin_irq_mode;
	logic [11:0] load_q[$];
	int wake_cnt;
	int cycles;
	int err_total;
	int samples_checked;

	irq_ctrl dut_u (.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .ext_pin(ext_pin),
		.comparator_out(comparator_out), .adc_done(src[9]),
		.tmr01_match(src[8:5]), .tmr3_match(src[4:2]),
		.eeprom_done(src[1]), .low_supply(src[0]),
		.timebase_source_clock(tb_src_clk), .next_pc(next_pc),
		.call_req(call_req), .ret_req(ret_req),
		.return_from_interrupt(return_from_interrupt_req), .pc_load(pc_load),
		.pc_addr(pc_addr), .stack_full(stack_full), .wake(wake),
		.pin_irq_mode(pin_irq_mode));

	core_model core_u (.clk(clk), .rst(rst), .op_cmd(op_cmd),
		.pc_load(pc_load), .pc_addr(pc_addr), .next_pc(next_pc),
		.call_req(call_req), .ret_req(ret_req),
		.return_from_interrupt(return_from_interrupt_req));

	// ==========================================
	// Clock, monitors and timeout
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Source at clk/4: each level must outlast the synchroniser's agreement
	always @(posedge clk) begin
		if (cycles % 2 == 0)
			tb_src_clk <= ~tb_src_clk;
		cycles++;
		if (pc_load === 1'b1)
			load_q.push_back(pc_addr);
		if (wake === 1'b1)
			wake_cnt++;
		if (cycles == 40000) begin
			err_total++;
			$display("MISMATCH timeout expected done seen running");
			summarize();
		end
	end

	// ==========================================
	// Tasks
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		address <= a;
		writedata <= {24'h00_0000, d};
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		if (n >= 50)
			chk("waitrequest", 32'h0000_0000, 32'h0000_0001);
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input string name, input logic [5:0] a,
		input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(name, {24'h00_0000, exp}, q);
	endtask : rd

	task automatic fire(input logic [9:0] v);
		@(posedge clk);
		src <= v;
		@(posedge clk);
		src <= 10'h000;
		repeat (4) @(posedge clk);
	endtask : fire

	task automatic core(input logic [2:0] op);
		@(posedge clk);
		op_cmd <= op;
		@(posedge clk);
		op_cmd <= 3'h0;
		repeat (3) @(posedge clk);
	endtask : core

	task automatic take(input logic [11:0] exp);
		int n;
		n = 0;
		while (load_q.size() == 0 && n < 30) begin
			@(posedge clk);
			n++;
		end
		if (load_q.size() == 0)
			chk("pc_load", 32'h0000_0001, 32'h0000_0000);
		else
			chk("pc_addr", {20'h0_0000, exp}, {20'h0_0000, load_q.pop_front()});
	endtask : take

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		chk("load_count", 32'h0000_0000, 32'(load_q.size()));
	endtask : idle

	function automatic logic [11:0] vec(input int i);
		return irq_pkg::VEC_BASE + 12'(i << irq_pkg::VEC_SHIFT);
	endfunction : vec

	task automatic summarize;
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	// ==========================================
	// Main sequence
	initial begin
		int n;
		int w;
		{rst, read, write, address, writedata} = {1'b1, 40'h00_0000_0000};
		{ext_pin, comparator_out, src, op_cmd, tb_src_clk} = 16'h0000;
		{wake_cnt, cycles, err_total, samples_checked} = 128'h0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pin_irq_mode", 32'h0, {31'h0, pin_irq_mode});
		rd("edge", irq_pkg::OFS_EDGE, 8'h03);
		rd("tbc", irq_pkg::OFS_TBC, 8'h37);
		rd("grp1", irq_pkg::OFS_GRP1, 8'h00);
		rd("grp2", irq_pkg::OFS_GRP2, 8'h00);
		rd("unmapped", 6'h24, 8'h00);
		wr(irq_pkg::OFS_GRP1, 8'hFF);
		rd("grp1", irq_pkg::OFS_GRP1, 8'h77);
		wr(irq_pkg::OFS_GRP2, 8'hFF);
		rd("grp2", irq_pkg::OFS_GRP2, 8'h33);
		wr(irq_pkg::OFS_GRP1, 8'h00);
		wr(irq_pkg::OFS_GRP2, 8'h00);
		// Every edge code, rising then falling
		for (int c = 0; c < 4; c++) begin
			wr(irq_pkg::OFS_EDGE, 8'(c));
			wr(irq_pkg::OFS_CTRL0, 8'h02);
			ext_pin <= 1'b1;
			repeat (8) @(posedge clk);
			rd("pin_rise", irq_pkg::OFS_CTRL0, 8'h02 | 8'(c & 1) << 4);
			wr(irq_pkg::OFS_CTRL0, 8'h02);
			ext_pin <= 1'b0;
			repeat (8) @(posedge clk);
			rd("pin_fall", irq_pkg::OFS_CTRL0, 8'h02 | 8'(c & 2) << 3);
		end
		chk("pin_irq_mode", 32'h1, {31'h0, pin_irq_mode});
		ext_pin <= 1'b1;
		repeat (8) @(posedge clk);
		wr(irq_pkg::OFS_CTRL0, 8'h13);
		take(vec(irq_pkg::SRC_PIN));
		rd("pin_served", irq_pkg::OFS_CTRL0, 8'h02);
		core(3'h4);
		take(12'h100);
		wr(irq_pkg::OFS_CTRL0, 8'h00);
		// Flag without enable, then enables without global enable
		w = wake_cnt;
		fire(10'h200);
		chk("wake", 32'(w + 1), 32'(wake_cnt));
		wr(irq_pkg::OFS_CTRL0, 8'h01);
		idle(10);
		rd("adc_flag", irq_pkg::OFS_CTRL1, 8'h40);
		wr(irq_pkg::OFS_CTRL0, 8'h04);
		wr(irq_pkg::OFS_CTRL1, 8'h44);
		comparator_out <= 1'b1;
		idle(10);
		rd("cmp_flag", irq_pkg::OFS_CTRL0, 8'h24);
		wr(irq_pkg::OFS_CTRL0, 8'h25);
		take(vec(irq_pkg::SRC_CMP));
		rd("cmp_served", irq_pkg::OFS_CTRL0, 8'h04);
		core(3'h4);
		take(12'h100);
		take(vec(irq_pkg::SRC_ADC));
		rd("adc_served", irq_pkg::OFS_CTRL1, 8'h04);
		core(3'h4);
		take(12'h100);
		wr(irq_pkg::OFS_CTRL0, 8'h00);
		// Full stack holds an enabled request back
		repeat (4) core(3'h1);
		chk("stack_full", 32'h1, {31'h0, stack_full});
		rd("stat", irq_pkg::OFS_STAT, 8'h0C);
		wr(irq_pkg::OFS_CTRL1, 8'h44);
		wr(irq_pkg::OFS_CTRL0, 8'h01);
		idle(12);
		rd("pending", irq_pkg::OFS_CTRL1, 8'h44);
		core(3'h2);
		take(12'h100);
		take(vec(irq_pkg::SRC_ADC));
		core(3'h2);
		take(12'h100);
		rd("plain_ret", irq_pkg::OFS_CTRL0, 8'h00);
		repeat (3) core(3'h2);
		rd("stat", irq_pkg::OFS_STAT, 8'h00);
		load_q.delete();
		wr(irq_pkg::OFS_CTRL1, 8'h00);
		// Group members
		wr(irq_pkg::OFS_GRP2, 8'h02);
		fire(10'h1FF);
		rd("grp0", irq_pkg::OFS_GRP0, 8'hF0);
		rd("grp1", irq_pkg::OFS_GRP1, 8'h70);
		rd("grp2", irq_pkg::OFS_GRP2, 8'h32);
		rd("mf_flags", irq_pkg::OFS_CTRL1, 8'h20);
		wr(irq_pkg::OFS_CTRL1, 8'h22);
		wr(irq_pkg::OFS_CTRL0, 8'h01);
		take(vec(irq_pkg::SRC_MF2));
		rd("members_kept", irq_pkg::OFS_GRP2, 8'h32);
		rd("mf_served", irq_pkg::OFS_CTRL1, 8'h02);
		core(3'h4);
		take(12'h100);
		wr(irq_pkg::OFS_CTRL0, 8'h00);
		wr(irq_pkg::OFS_CTRL1, 8'h00);
		// Time base A at 256 ticks of clk/4
		wr(irq_pkg::OFS_TBC, 8'hC0);
		n = cycles;
		w = wake_cnt;
		while (wake_cnt == w && cycles - n < 1100)
			@(posedge clk);
		n = cycles - n;
		chk("tba_period", 32'h1, {31'h0, n >= 1016 && n <= 1036});
		rd("tba_flag", irq_pkg::OFS_CTRL1, 8'h80);
		wr(irq_pkg::OFS_CTRL1, 8'h88);
		wr(irq_pkg::OFS_CTRL0, 8'h01);
		take(vec(irq_pkg::SRC_TBA));
		rd("tba_served", irq_pkg::OFS_CTRL1, 8'h08);
		wr(irq_pkg::OFS_TBC, 8'h00);
		// Time base B at 4096 ticks of the external source
		wr(irq_pkg::OFS_TBC, 8'h87);
		n = cycles;
		w = wake_cnt;
		while (wake_cnt == w && cycles - n < 17000)
			@(posedge clk);
		n = cycles - n;
		chk("tbb_period", 32'h1, 32'(n >= 16376 && n <= 16396));
		rd("tbb_flag", irq_pkg::OFS_CTRL2, 8'h10);
		wr(irq_pkg::OFS_CTRL2, 8'h11);
		wr(irq_pkg::OFS_CTRL0, 8'h01);
		take(vec(irq_pkg::SRC_TBB));
		rd("tbb_served", irq_pkg::OFS_CTRL2, 8'h01);
		wr(irq_pkg::OFS_TBC, 8'h00);
		summarize();
	end
endmodule : irq_ctrl_tb_top
